// file: core/spm_pkg.sv
// Purpose: Shared constants and types of the serial peripheral port
// Assumes: One system clock; every pin input is synchronised inside the core
// Notes:   Configuration travels as one packed word of type spm_cfg_t
package spm_pkg;

  // ==========================================================================
  // Role codes and sizes
  // ==========================================================================
  localparam logic [1:0] ROLE_SLAVE   = 2'h2;
  localparam logic [1:0] ROLE_MASTER  = 2'h3;
  localparam int         CHAR_W       = 9;
  localparam logic [3:0] LEN_EIGHT    = 4'h8;
  localparam logic [3:0] LEN_NINE     = 4'h9;
  localparam int         RXBUF_DEPTH  = 2;

  // ==========================================================================
  // Timing counts in system clock cycles or SCK cycles
  // ==========================================================================
  localparam logic [1:0] SYNC_CYC     = 2'h2;  // Enable and disable settling
  localparam logic [1:0] DRE_DLY      = 2'h3;  // Holding empty to flag
  localparam logic [1:0] SLV_LOAD_SCK = 2'h3;  // SCK cycles before slave load

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [8:0]  SHIFT_RESET = 9'h000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [1:0] role;        // role_select_field
    logic       clock_idle_level;        // clock_idle_level
    logic       clock_sample_phase;        // clock_sample_phase
    logic       bit_order;        // bit_order, 1 sends LSB first
    logic       character_length;      // character_length, 1 selects nine bits
    logic       hw_select_enable;       // hw_select_enable
    logic       immediate_overflow_notice;        // immediate_overflow_notice
    logic [7:0] baud;        // Rate divider
  } spm_cfg_t;

  typedef struct packed {
    logic [8:0] data;
    logic       ovf;         // Overflow marker travelling with the data
  } spm_rx_t;

  typedef enum logic [1:0] {
    EN_OFF     = 2'b00,
    EN_RISING  = 2'b01,
    EN_ON      = 2'b10,
    EN_FALLING = 2'b11
  } spm_en_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LEAD = 2'b01,
    M_XFER = 2'b10,
    M_TAIL = 2'b11
  } spm_mst_t;

endpackage

// file: core/spm_rxbuf.sv
// Purpose: Two-level receive buffer with overflow detection and marker
// Assumes: Push and pop are single-cycle strobes on the system clock
// Notes:   A pop is served before a push in the same cycle
module spm_rxbuf
  import spm_pkg::*;
(
  input  wire logic    i_clk,
  input  wire logic    i_reset_n,
  input  wire logic    i_flush,
  input  wire logic    i_push,
  input  wire logic [8:0] i_push_data,
  input  wire logic    i_pop,
  input  wire logic    i_immediate_overflow_notice,
  output logic         o_valid,
  output spm_rx_t      o_head,
  output logic         o_ovf_now
);

  spm_rx_t    mem_r [RXBUF_DEPTH];
  logic [1:0] cnt_r;
  logic       pop;
  logic       full;

  assign pop     = i_pop && (cnt_r != 2'h0);
  assign full    = (cnt_r == 2'h2) && !pop;
  assign o_valid = (cnt_r != 2'h0);
  assign o_head  = mem_r[0];

  // ==========================================================================
  // Storage and level
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r     <= 2'h0;
      o_ovf_now <= 1'b0;
      mem_r[0]  <= '0;
      mem_r[1]  <= '0;
    end else if (i_flush) begin
      cnt_r     <= 2'h0;
      o_ovf_now <= 1'b0;
      mem_r[0]  <= '0;
      mem_r[1]  <= '0;
    end else begin
      o_ovf_now <= i_push && full;
      // Head advances on a read
      if (pop) begin
        mem_r[0] <= mem_r[1];
        mem_r[1] <= '0;
      end
      if (i_push && !full) begin
        if ((cnt_r == 2'h0) || (pop && cnt_r == 2'h1)) begin
          mem_r[0] <= '{data: i_push_data, ovf: 1'b0};
        end else begin
          mem_r[1] <= '{data: i_push_data, ovf: 1'b0};
        end
        cnt_r <= pop ? cnt_r : cnt_r + 2'h1;
      end else if (i_push && full) begin
        // Incoming character dropped; marker rides on newest entry unless immediate notice is set
        if (!i_immediate_overflow_notice) begin
          mem_r[1].ovf <= 1'b1;
        end
      end else if (pop) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

endmodule

// file: core/spm_core.sv
// Purpose: Serial peripheral port of the serial_comm_module, master or slave
// Assumes: Pins are asynchronous and pass two flip-flops; baud of 3 or more
// Notes:   Control bits are plain ports; writes are single-cycle strobes
//
// Summary of operation
// - Protected config writes dropped while enabled, deferred while disabling
// - Role field 0x2 slave, 0x3 master
// - Characters of eight or nine bits
// - Soft reset clears all but debug control
// - Master SCK from 8-bit rate divider
// - Slave shifts on the incoming SCK
// - One data port: write holding, read receive head
// - Four clock modes sample and set up on opposite edges
// - Holding moves when shift register empty, then empty flag
// - Received character buffered on last bit, done flag
// - Master transfer done when nothing left to send
// - Select low starts, high ends; one received per sent
// - Master drives select when hardware select enabled
// - Slave idle, MISO released while select high
// - Slave transfer done on select returning high
// - Slave data loadable after three SCK cycles, at boundary
// - Late slave data sends previous received character
// - Empty flag three clocks after holding empties
// - Overflow status sticky, cleared by write or receiver off
// - Immediate notice sets overflow on overflow
// - Marker reaches head: overflow, error, done, zero data
// - Access guard locks config except while debug halted or for debugger accesses
// - Debug stop halts baud generator during debug halt
module spm_core
  import spm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Control
  input  wire logic       i_enable,
  input  wire logic       i_soft_reset,
  input  wire logic       i_cfg_wr,
  input  spm_cfg_t        i_cfg,
  input  wire logic       i_receiver_on_wr,
  input  wire logic       i_receiver_on,
  input  wire logic       i_dbg_wr,
  input  wire logic       i_dbg_stop,
  input  wire logic       i_guard_lock,
  input  wire logic       i_cpu_dbg_halt,
  input  wire logic       i_ext_dbg_access,
  // Data and flags
  input  wire logic       i_data_wr,
  input  wire logic [8:0] i_data_wdata,
  input  wire logic       i_data_rd,
  input  wire logic       i_clr_txc,
  input  wire logic       i_clr_ovf,
  input  wire logic       i_clr_err,
  output logic [8:0]      o_data_rdata,
  output logic            o_tx_empty,
  output logic            o_rx_done,
  output logic            o_tx_done,
  output logic            o_err,
  output logic            o_overflow,
  output logic            o_enabled,
  output spm_cfg_t        o_cfg,
  // Pins
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  input  wire logic       i_ss_n,
  output logic            o_sck,
  output logic            o_sck_oe_n,
  output logic            o_mosi,
  output logic            o_mosi_oe_n,
  output logic            o_miso,
  output logic            o_miso_oe_n,
  output logic            o_ss_n,
  output logic            o_ss_oe_n
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  spm_en_t    en_st_r;
  logic [1:0] en_cnt_r;
  spm_cfg_t   cfg_r, pend_cfg_r;
  logic       pend_r, receiver_on_r, dbg_stop_r;
  logic       wr_ok, srst, run, master, slave;
  logic [3:0] sync1_r, sync2_r;
  logic       sck_d_r, ss_d_r;
  logic       sck_s, mosi_s, miso_s, ss_s;
  logic [8:0] hold_r, sh_r;
  logic       hold_v_r;
  logic [1:0] hold_age_r, dre_cnt_r;
  logic [3:0] len, bcnt_r;
  logic [4:0] ecnt_r;
  logic       last_edge;
  logic       dout_r, lead_ev, trail_ev, sample_ev, setup_ev;
  logic       in_bit, done_char, load_now, hold_ready;
  spm_mst_t   mst_r;
  logic [7:0] bcount_r;
  logic       tick, sck_r, more_r, baud_halt;
  logic       txc_set, ss_rise, ovf_set, err_set;
  logic       rx_valid, rx_ovf_now;
  spm_rx_t    rx_head;

  assign master = (cfg_r.role == ROLE_MASTER);
  assign slave  = (cfg_r.role == ROLE_SLAVE);
  assign run    = (en_st_r == EN_ON);
  assign srst   = i_soft_reset;
  assign len    = cfg_r.character_length ? LEN_NINE : LEN_EIGHT;
  assign o_cfg  = cfg_r;
  assign o_enabled = (en_st_r != EN_OFF);

  // Guard lifted during debug halt and for debugger accesses
  assign wr_ok = !i_guard_lock || i_cpu_dbg_halt || i_ext_dbg_access;

  // ==========================================================================
  // Enable sequencing and protected configuration
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_st_r    <= EN_OFF;
      en_cnt_r   <= 2'h0;
      cfg_r      <= CFG_RESET;
      pend_cfg_r <= CFG_RESET;
      pend_r     <= 1'b0;
    end else if (srst) begin
      en_st_r    <= EN_OFF;
      en_cnt_r   <= 2'h0;
      cfg_r      <= CFG_RESET;
      pend_cfg_r <= CFG_RESET;
      pend_r     <= 1'b0;
    end else begin
      en_cnt_r <= (en_cnt_r == 2'h0) ? 2'h0 : en_cnt_r - 2'h1;
      unique case (en_st_r)
        EN_OFF: begin
          if (i_cfg_wr && wr_ok) begin
            cfg_r <= i_cfg;
          end
          if (i_enable) begin
            en_st_r  <= EN_RISING;
            en_cnt_r <= SYNC_CYC;
          end
        end
        EN_RISING: begin
          if (en_cnt_r == 2'h1) begin
            en_st_r <= EN_ON;
          end
        end
        EN_ON: begin
          if (!i_enable) begin
            en_st_r  <= EN_FALLING;
            en_cnt_r <= SYNC_CYC;
          end
        end
        EN_FALLING: begin
          // Writes made while shutting down land afterwards
          if (i_cfg_wr && wr_ok) begin
            pend_cfg_r <= i_cfg;
            pend_r     <= 1'b1;
          end
          if (en_cnt_r == 2'h1) begin
            en_st_r <= EN_OFF;
            if (pend_r) begin
              cfg_r <= pend_cfg_r;
            end
            pend_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Receiver enable and debug stop are not enable-protected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      receiver_on_r     <= 1'b0;
      dbg_stop_r <= 1'b0;
    end else begin
      if (srst) begin
        receiver_on_r <= 1'b0;
      end else if (i_receiver_on_wr && wr_ok) begin
        receiver_on_r <= i_receiver_on;
      end
      if (i_dbg_wr && wr_ok) begin
        dbg_stop_r <= i_dbg_stop;
      end
    end
  end

  // ==========================================================================
  // Pin synchronisers: sck, mosi, miso, select
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_r <= 4'h8;                                       // Select high, SCK idle low
      sync2_r <= 4'h8;
      sck_d_r <= 1'b0;
      ss_d_r  <= 1'b1;
    end else begin
      sync1_r <= {i_ss_n, i_miso, i_mosi, i_sck};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[0];
      ss_d_r  <= sync2_r[3];
    end
  end
  assign sck_s  = sync2_r[0];
  assign mosi_s = sync2_r[1];
  assign miso_s = sync2_r[2];
  assign ss_s   = sync2_r[3];
  assign ss_rise = slave && run && ss_s && !ss_d_r;

  // ==========================================================================
  // Baud generator, master sequencer
  // ==========================================================================
  assign baud_halt = dbg_stop_r && i_cpu_dbg_halt;
  assign tick = (bcount_r == cfg_r.baud) && !baud_halt;
  // Last of the 2*len SCK edges; nine-bit characters need 18 edges
  assign last_edge = (ecnt_r == {len - 4'h1, 1'b1});

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bcount_r <= 8'h00;
    end else if (srst || mst_r == M_IDLE || tick) begin
      bcount_r <= 8'h00;
    end else if (!baud_halt) begin
      bcount_r <= bcount_r + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mst_r  <= M_IDLE;
      sck_r  <= 1'b0;
      ecnt_r <= 5'h00;
    end else if (srst || !run || !master) begin
      mst_r  <= M_IDLE;
      sck_r  <= cfg_r.clock_idle_level;
      ecnt_r <= 5'h00;
    end else begin
      unique case (mst_r)
        M_IDLE: begin
          if (hold_v_r) begin
            mst_r <= M_LEAD;
          end
        end
        M_LEAD: begin
          if (tick) begin
            mst_r <= M_XFER;
          end
        end
        M_XFER: begin
          if (tick) begin
            sck_r  <= ~sck_r;
            ecnt_r <= ecnt_r + 5'h01;
            if (last_edge) begin
              ecnt_r <= 5'h00;
              mst_r  <= more_r ? M_XFER : M_TAIL;
            end
          end
        end
        M_TAIL: begin
          if (tick) begin
            mst_r <= M_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Edge events shared by both roles
  // ==========================================================================
  always_comb begin
    lead_ev  = 1'b0;
    trail_ev = 1'b0;
    if (run && master && mst_r == M_XFER && tick) begin
      lead_ev  = !ecnt_r[0];
      trail_ev = ecnt_r[0];
    end else if (run && slave && !ss_s) begin
      lead_ev  = (sck_s != cfg_r.clock_idle_level) && (sck_d_r == cfg_r.clock_idle_level);
      trail_ev = (sck_s == cfg_r.clock_idle_level) && (sck_d_r != cfg_r.clock_idle_level);
    end
  end
  // Sample and setup on opposite edges
  assign sample_ev = cfg_r.clock_sample_phase ? trail_ev : lead_ev;
  assign setup_ev  = cfg_r.clock_sample_phase ? lead_ev : trail_ev;
  assign in_bit    = master ? miso_s : mosi_s;
  assign done_char = sample_ev && (bcnt_r == len - 4'h1);
  assign hold_ready = hold_v_r && (master || hold_age_r == SLV_LOAD_SCK);
  assign load_now  = (master && mst_r == M_IDLE && hold_v_r) ||
                     (done_char && hold_ready);

  // ==========================================================================
  // Holding register and empty flag timing
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_r     <= SHIFT_RESET;
      hold_v_r   <= 1'b0;
      hold_age_r <= 2'h0;
      dre_cnt_r  <= 2'h0;
    end else if (srst) begin
      hold_r     <= SHIFT_RESET;
      hold_v_r   <= 1'b0;
      hold_age_r <= 2'h0;
      dre_cnt_r  <= 2'h0;
    end else begin
      if (i_data_wr) begin
        hold_r     <= i_data_wdata;
        hold_v_r   <= 1'b1;
        hold_age_r <= 2'h0;
        dre_cnt_r  <= 2'h0;
      end else if (load_now) begin
        hold_v_r <= 1'b0;
      end else if (!hold_v_r && dre_cnt_r != DRE_DLY) begin
        dre_cnt_r <= dre_cnt_r + 2'h1;
      end
      // Slave data ages in SCK cycles before it may be loaded
      if (!i_data_wr && hold_v_r && sample_ev && hold_age_r != SLV_LOAD_SCK) begin
        hold_age_r <= hold_age_r + 2'h1;
      end
    end
  end
  assign o_tx_empty = !hold_v_r && (dre_cnt_r == DRE_DLY);

  // ==========================================================================
  // Shift register and output bit
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_r   <= SHIFT_RESET;
      dout_r <= 1'b0;
      bcnt_r <= 4'h0;
      more_r <= 1'b0;
    end else if (srst) begin
      sh_r   <= SHIFT_RESET;
      dout_r <= 1'b0;
      bcnt_r <= 4'h0;
      more_r <= 1'b0;
    end else begin
      if (slave && ss_s) begin
        bcnt_r <= 4'h0;
      end else if (sample_ev) begin
        bcnt_r <= done_char ? 4'h0 : bcnt_r + 4'h1;
        if (cfg_r.bit_order) begin
          sh_r <= (sh_r >> 1);
          sh_r[len - 4'h1] <= in_bit;
        end else begin
          sh_r <= {sh_r[7:0], in_bit};
        end
      end
      // Without new data the received character stays to go out
      if (load_now) begin
        sh_r <= hold_r;
        if (!cfg_r.clock_sample_phase) begin
          dout_r <= cfg_r.bit_order ? hold_r[0] : hold_r[len - 4'h1];
        end
      end else if (setup_ev) begin
        dout_r <= cfg_r.bit_order ? sh_r[0] : sh_r[len - 4'h1];
      end
      if (done_char) begin
        more_r <= hold_v_r;
      end
    end
  end

  // ==========================================================================
  // Receive buffer and status flags
  // ==========================================================================
  spm_rxbuf u_rxbuf (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_flush     (srst || !receiver_on_r),
    .i_push      (done_char && receiver_on_r),
    .i_push_data (cfg_r.bit_order ? ((sh_r >> 1) | ({8'h00, in_bit} << (len - 4'h1)))
                             : ({sh_r[7:0], in_bit} & (cfg_r.character_length ? 9'h1FF : 9'h0FF))),
    .i_pop       (i_data_rd),
    .i_immediate_overflow_notice      (cfg_r.immediate_overflow_notice),
    .o_valid     (rx_valid),
    .o_head      (rx_head),
    .o_ovf_now   (rx_ovf_now)
  );
  assign o_rx_done    = rx_valid;
  assign o_data_rdata = rx_head.ovf ? 9'h000 : rx_head.data;
  assign ovf_set = (cfg_r.immediate_overflow_notice && rx_ovf_now) ||
                   (rx_valid && rx_head.ovf);
  assign err_set = rx_valid && rx_head.ovf;
  assign txc_set = (master && mst_r == M_XFER && tick &&
                    last_edge && !more_r) ||
                   ss_rise;

  // Sticky flags: a set beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_overflow <= 1'b0;
      o_err      <= 1'b0;
      o_tx_done  <= 1'b0;
    end else if (srst) begin
      o_overflow <= 1'b0;
      o_err      <= 1'b0;
      o_tx_done  <= 1'b0;
    end else begin
      if (ovf_set) begin
        o_overflow <= 1'b1;
      end else if (i_clr_ovf || !receiver_on_r) begin
        o_overflow <= 1'b0;
      end
      if (err_set) begin
        o_err <= 1'b1;
      end else if (i_clr_err) begin
        o_err <= 1'b0;
      end
      if (txc_set) begin
        o_tx_done <= 1'b1;
      end else if (i_clr_txc) begin
        o_tx_done <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sck       <= 1'b0;
      o_sck_oe_n  <= 1'b1;
      o_mosi      <= 1'b0;
      o_mosi_oe_n <= 1'b1;
      o_miso      <= 1'b0;
      o_miso_oe_n <= 1'b1;
      o_ss_n      <= 1'b1;
      o_ss_oe_n   <= 1'b1;
    end else begin
      o_sck       <= sck_r;
      o_sck_oe_n  <= !(run && master);
      o_mosi      <= dout_r;
      o_mosi_oe_n <= !(run && master);
      o_miso      <= dout_r;
      o_miso_oe_n <= !(run && slave && !ss_s);
      o_ss_n      <= (mst_r == M_IDLE);
      o_ss_oe_n   <= !(run && master && cfg_r.hw_select_enable);
    end
  end

endmodule

// file: test/spm_core_assertions.sv
// Purpose: Port checks of the serial peripheral port
// Assumes: One clock; asynchronous active-low reset
// Notes:   Bound to spm_core from the bench top
module spm_core_assertions
  import spm_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_soft_reset,
  input wire logic       i_receiver_on_wr,
  input wire logic       i_receiver_on,
  input wire logic       i_data_wr,
  input wire logic       i_clr_txc,
  input wire logic       i_clr_ovf,
  input wire logic       i_ss_n,
  input wire logic [8:0] o_data_rdata,
  input wire logic       o_tx_empty,
  input wire logic       o_rx_done,
  input wire logic       o_tx_done,
  input wire logic       o_err,
  input wire logic       o_overflow,
  input wire logic       o_enabled,
  input spm_cfg_t        o_cfg,
  input wire logic       o_sck,
  input wire logic       o_miso_oe_n,
  input wire logic       o_ss_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // =====
  // Assertions
  a_cfg_locked: assert property (o_enabled && $past(o_enabled) && !$past(i_soft_reset)
    |-> $stable(o_cfg)) else $error("config changed while enabled");
  a_wr_empty: assert property (i_data_wr && !i_soft_reset |=> !o_tx_empty [*3])
    else $error("empty flag too early");
  a_sck_framed: assert property (o_enabled && $past(o_enabled, 4) && o_cfg.hw_select_enable
    && o_cfg.role == ROLE_MASTER && $changed(o_sck) |-> !o_ss_n)
    else $error("clock edge outside select");
  a_slave_quiet: assert property (o_cfg.role == ROLE_SLAVE && i_ss_n [*6] |-> o_miso_oe_n)
    else $error("slave drives data while deselected");
  a_txc_sticky: assert property (o_tx_done && !i_clr_txc && !i_soft_reset |=> o_tx_done)
    else $error("transfer done dropped");
  a_ovf_sticky: assert property (o_overflow && !i_clr_ovf && !i_soft_reset && !i_receiver_on_wr
    && !$past(i_receiver_on_wr)
    |=> o_overflow) else $error("overflow dropped");
  a_rxoff_flush: assert property (i_receiver_on_wr && !i_receiver_on && !i_soft_reset
    |-> ##[1:3] (!o_overflow && !o_rx_done)) else $error("receiver off kept state");
  a_mark_head: assert property ($rose(o_err) && !o_cfg.immediate_overflow_notice
    |-> o_overflow && $past(o_rx_done) && $past(o_data_rdata) == 9'h000)
    else $error("marked head wrong");
  // Main scenarios
  c_tx_done: cover property ($rose(o_tx_done));
  c_overflow: cover property ($rose(o_overflow));
  c_slave_on: cover property (o_cfg.role == ROLE_SLAVE && o_enabled);
endmodule

// file: test/spm_slave_model.sv
// Purpose: Behavioural far-side slave for the master role
// Assumes: Mode given by idle level and phase inputs
// Notes:   Sends one fixed byte per character, keeps what it hears
module spm_slave_model
  import spm_pkg::*;
#(
  parameter logic [7:0] REPLY = 8'h3C
)
(
  input  wire logic       i_sck,
  input  wire logic       i_ss_n,
  input  wire logic       i_mosi,
  input  wire logic       i_clock_idle_level,
  input  wire logic       i_clock_sample_phase,
  output logic            o_miso,
  output logic [7:0]      o_heard
);
  int         n_smp = 0;
  logic [2:0] bit_ix = 3'h0;
  // =====
  // Frame start restarts the bit count
  always @(negedge i_ss_n) begin
    n_smp = 0;
    bit_ix = 3'h0;
  end
  // Sample on one edge, set up on the other
  always @(i_sck) begin
    if (!i_ss_n && i_sck == !(i_clock_idle_level ^ i_clock_sample_phase)) begin
      o_heard = {o_heard[6:0], i_mosi};
      n_smp = n_smp + 1;
    end else if (!i_ss_n && n_smp != 0) begin
      bit_ix = 3'(n_smp % 8);
    end
  end
  // Released line shows the inverse of the bit at the current bit index
  assign o_miso = i_ss_n ? ~REPLY[~bit_ix] : REPLY[~bit_ix];
endmodule

// file: test/tb_spi_master_slave_port.sv
// Purpose: Self-checking bench for the serial peripheral port
// Assumes: Master transfers against a behavioural slave
// Notes:   Reads are matched by a monitor against a queue of notes
module tb_spi_master_slave_port
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst_n = 0, en = 0, srst = 0, cfg_wr = 0, receiver_on_wr = 0, receiver_on = 0;
  logic       dwr = 0, drd = 0, clr_txc = 0, clr_ovf = 0, lock = 0, halt = 0;
  logic [8:0] wdata = 9'h000;
  spm_cfg_t   cfg = '0;
  spm_cfg_t   cfg_o;
  wire  [8:0] rdata;
  wire  [7:0] heard;
  wire        tx_empty, rx_done, tx_done, err, ovf, enabled, sck, mosi, miso, ss_n, miso_oe_n;
  int         err_total = 0, check_count = 0, cyc = 0;
  logic [8:0] notes[$];
  spm_core u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_enable(en), .i_soft_reset(srst),
    .i_cfg_wr(cfg_wr), .i_cfg(cfg), .i_receiver_on_wr(receiver_on_wr), .i_receiver_on(receiver_on), .i_dbg_wr(1'b0),
    .i_dbg_stop(1'b0), .i_guard_lock(lock), .i_cpu_dbg_halt(halt), .i_ext_dbg_access(1'b0),
    .i_data_wr(dwr), .i_data_wdata(wdata), .i_data_rd(drd), .i_clr_txc(clr_txc),
    .i_clr_ovf(clr_ovf), .i_clr_err(clr_ovf), .o_data_rdata(rdata), .o_tx_empty(tx_empty),
    .o_rx_done(rx_done), .o_tx_done(tx_done), .o_err(err), .o_overflow(ovf),
    .o_enabled(enabled), .o_cfg(cfg_o), .i_sck(sck), .i_mosi(mosi), .i_miso(miso),
    .i_ss_n(ss_n), .o_sck(sck), .o_sck_oe_n(), .o_mosi(mosi), .o_mosi_oe_n(), .o_miso(),
    .o_miso_oe_n(miso_oe_n), .o_ss_n(ss_n), .o_ss_oe_n());
  spm_slave_model u_slave (.i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .i_clock_idle_level(cfg_o.clock_idle_level),
    .i_clock_sample_phase(cfg_o.clock_sample_phase), .o_miso(miso), .o_heard(heard));
  // =====
  // Clock, timeout and read monitor
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (drd && rx_done) compare(16'(rdata), 16'(notes.pop_front()));
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Disable, write config during disabling, re-enable
  task automatic set_cfg(input logic [1:0] r, input logic [1:0] m, input logic ib);
    en = 0;
    tick(1);
    cfg = '{role: r, clock_idle_level: m[1], clock_sample_phase: m[0], bit_order: 0, character_length: 0, hw_select_enable: 1, immediate_overflow_notice: ib, baud: 8'h04};
    cfg_wr = 1;
    tick(1);
    cfg_wr = 0;
    tick(4);
    compare(16'(cfg_o), 16'(cfg));
    en = 1;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] d);
    wdata = {1'b0, d};
    dwr = 1;
    tick(1);
    dwr = 0;
    for (int i = 0; i < 300 && tx_done !== 1'b1; i++) tick(1);
    // Last pin edge follows the done flag by one clock
    tick(1);
    compare(16'(tx_empty), 16'h0001);
    compare(16'(tx_done), 16'h0001);
    compare(16'(heard), 16'(d));
    clr_txc = 1;
    tick(1);
    clr_txc = 0;
  endtask
  // =====
  // Main sequence
  initial begin
    void'($urandom(32'h3400));
    tick(2);
    rst_n = 1;
    receiver_on_wr = 1;
    receiver_on = 1;
    tick(1);
    receiver_on_wr = 0;
    for (int m = 0; m < 4; m++) begin
      set_cfg(ROLE_MASTER, 2'(m), 1'b0);
      xfer(8'($urandom));
      notes.push_back(9'h03C);
      drd = 1;
      tick(1);
      drd = 0;
    end
    cfg.baud = 8'h09;
    cfg_wr = 1;
    tick(1);
    cfg_wr = 0;
    tick(2);
    compare(16'(cfg_o.baud), 16'h0004);
    set_cfg(ROLE_SLAVE, 2'h0, 1'b0);
    tick(8);
    compare(16'(miso_oe_n), 16'h0001);
    srst = 1;
    en = 0;
    tick(1);
    srst = 0;
    tick(1);
    compare({15'h0000, enabled}, 16'h0000);
    compare(16'(cfg_o), 16'(CFG_RESET));
    // Guarded write refused, then taken while halted in debug
    lock = 1;
    cfg_wr = 1;
    tick(1);
    compare(16'(cfg_o), 16'(CFG_RESET));
    halt = 1;
    tick(1);
    cfg_wr = 0;
    halt = 0;
    lock = 0;
    compare(16'(cfg_o), 16'(cfg));
    receiver_on_wr = 1;
    tick(1);
    receiver_on_wr = 0;
    set_cfg(ROLE_MASTER, 2'h0, 1'b0);
    repeat (3) xfer(8'($urandom));
    compare(16'(ovf), 16'h0000);
    notes.push_back(9'h03C);
    notes.push_back(9'h000);
    drd = 1;
    tick(2);
    drd = 0;
    compare(16'(ovf), 16'h0001);
    compare(16'(err), 16'h0001);
    compare(16'(notes.size()), 16'h0000);
    receiver_on = 0;
    receiver_on_wr = 1;
    tick(1);
    receiver_on_wr = 0;
    tick(3);
    compare(16'(ovf), 16'h0000);
    clr_ovf = 1;
    tick(1);
    clr_ovf = 0;
    compare(16'(err), 16'h0000);
    complete_run();
  end
endmodule
bind spm_core spm_core_assertions u_chk (.*);
